// ### shared/prot_cfg.svh
// offsets, field positions, codes, reset values and timing for the trip supervisor
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH

`define CLK_PERIOD_NS    10
`define TENTH_SECOND_NS  100000000

`define OFF_CONFIG       8'h00
`define OFF_LV_DELAY     8'h04
`define OFF_LV_LEVEL     8'h08
`define OFF_NO_MOTOR     8'h0c
`define OFF_INPUT_FUNC   8'h10
`define OFF_DECEL        8'h14
`define OFF_STATUS       8'h18
`define OFF_HOLD         8'h1c
`define OFF_IRQ_STATUS   8'h20
`define OFF_IRQ_MASK     8'h24

`define CFG_RELAY1_LSB   0
`define CFG_RELAY2_LSB   8
`define CFG_OPT_LSB      16
`define CFG_NMR_BIT      20
`define NM_LEVEL_LSB     0
`define NM_TIME_LSB      8
`define FUNC_WIDTH       6

`define FUNC_RESET       6'h03
`define FUNC_BLOCK       6'h05
`define FUNC_LV_WARN     6'h0b

`define NM_LEVEL_MIN     7'h01
`define NM_LEVEL_MAX     7'h64
`define NM_LEVEL_RST     7'h05
`define NM_TIME_MIN      8'h01
`define NM_TIME_MAX      8'h64
`define NM_TIME_RST      8'h1e
`define LV_DELAY_MAX     10'h258
`define LV_DELAY_RST     10'h000
`define LV_LEVEL_RST     16'h0000
`define DECEL_RST        16'h0000

`define EV_LV            0
`define EV_OPT           1
`define EV_NM            2
`define EV_BLOCK         3
`define EV_COUNT         4

`define FAN_PENDING      2'h1
`define FAN_CLEAR        2'h0

`endif

// ### shared/prot_pkg.sv
// types shared by the trip supervisor files
package prot_pkg;
  typedef enum logic [3:0] {
    st_stop  = 4'h1,
    st_run   = 4'h2,
    st_block = 4'h4,
    st_trip  = 4'h8
  } drive_state_t;

  typedef enum logic [1:0] {
    react_none     = 2'h0,
    react_free_run = 2'h1,
    react_decel    = 2'h2
  } reaction_t;
endpackage

// ### shared/timer_if.sv
// request and expiry between the supervisor and a tenth-second hold timer
`timescale 1ns/1ps
interface timer_if;
  logic       active;
  logic [9:0] limit;
  logic       expired;
  modport timer (input active, input limit, output expired);
  modport user  (output active, output limit, input expired);
endinterface

// ### hdl/hold_timer.sv
// counts tenths of a second while active; expires once the limit is reached
`timescale 1ns/1ps
module hold_timer #(
  parameter int unsigned tenth_cycles = 1
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  timer_if.timer     t
);
  localparam int PW = $clog2(tenth_cycles + 1);

  logic [PW-1:0] pre;
  logic [9:0]    tenths;
  wire           tick = (pre == PW'(tenth_cycles - 1));
  wire           at_limit = (tenths >= t.limit);

  // a limit of zero expires in the same cycle the condition appears
  assign t.expired = t.active && at_limit;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pre    <= '0;
      tenths <= 10'h000;
    end
    else if (!t.active)
    begin
      // any break in the condition restarts the count
      pre    <= '0;
      tenths <= 10'h000;
    end
    else
    begin
      pre <= tick ? '0 : pre + PW'(1);
      if (tick && !at_limit)
        tenths <= tenths + 10'h001;
    end
endmodule

// ### hdl/trip_supervisor.sv
// drive output-stage protection supervisor with an apb register file
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "prot_cfg.svh"
// Notes on behaviour
// (RQ1) low dc link blocks output at once
// (RQ2) low voltage trip declared after set delay
// (RQ3) relay with function 11 shows low voltage
// (RQ4) warning relay ignores the trip delay
// (RQ5) block input during run blocks, shows indication
// (RQ6) frequency and current held at block entry
// (RQ7) resume after block off and new command
// (RQ8) reset-function input clears latched trip
// (RQ9) keypad stop/reset key also clears trip
// (RQ10) fan status 01 means replacement pending
// (RQ11) option fault on link failure or removal; code sees removal only while running
// (RQ12) option reaction 0 none, 1 block trip
// (RQ13) option reaction 2 decelerates with decel time
// (RQ14) low current for detect time trips no-motor
// (RQ15) no-motor level 1 to 100 percent
// (RQ16) no-motor time 0.1 to 10 seconds
// (RQ17) no-motor reaction 0 none, 1 free-run
// (RQ18) operator lowers level for square-law pattern
// (RQ19) trips stay latched until a reset
module trip_supervisor #(
  parameter int unsigned tenth_cycles = `TENTH_SECOND_NS / `CLK_PERIOD_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] dc_link_voltage,
  input  wire logic [15:0] output_freq,
  input  wire logic [15:0] output_current,
  input  wire logic [7:0]  output_current_pct,
  input  wire logic [4:0]  multi_function_input,
  input  wire logic        run_cmd,
  input  wire logic        key_reset,
  input  wire logic        option_comm_fail,
  input  wire logic        option_present,
  input  wire logic        fan_exchange_due,
  output logic             output_block,
  output logic             decel_req,
  output logic      [15:0] trip_decel_time,
  output logic             relay_one,
  output logic             relay_two,
  output logic             trip_active,
  output logic             block_display,
  output logic      [1:0]  fan_replacement_status,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [4:0] inputs_with(input logic [29:0] funcs,
                                             input logic [5:0]  code);
    logic [4:0] m;
    m = 5'h00;
    for (int i = 0; i < 5; i++)
      m[i] = (funcs[i*`FUNC_WIDTH +: `FUNC_WIDTH] == code);
    return m;
  endfunction

  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] config_reg;
  logic [9:0]  lv_delay;
  logic [15:0] lv_level;
  logic [6:0]  nm_level;
  logic [7:0]  nm_time;
  logic [29:0] input_func;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [15:0] held_freq;
  logic [15:0] held_current;
  logic [2:0]  trip_cause;
  logic        trip_blocks;
  logic        run_cmd_q;
  logic        reset_in_q;
  logic        option_present_q;

  prot_pkg::drive_state_t state;
  prot_pkg::drive_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire         access   = psel && penable;
  wire         wr       = access && pwrite;
  wire         sel_cfg  = (paddr == `OFF_CONFIG);
  wire         sel_lvd  = (paddr == `OFF_LV_DELAY);
  wire         sel_lvl  = (paddr == `OFF_LV_LEVEL);
  wire         sel_nm   = (paddr == `OFF_NO_MOTOR);
  wire         sel_func = (paddr == `OFF_INPUT_FUNC);
  wire         sel_dec  = (paddr == `OFF_DECEL);
  wire         sel_sts  = (paddr == `OFF_STATUS);
  wire         sel_hold = (paddr == `OFF_HOLD);
  wire         sel_ist  = (paddr == `OFF_IRQ_STATUS);
  wire         sel_imsk = (paddr == `OFF_IRQ_MASK);
  wire         mapped   = sel_cfg | sel_lvd | sel_lvl | sel_nm | sel_func |
                          sel_dec | sel_sts | sel_hold | sel_ist | sel_imsk;

  wire [7:0]   wr_level = clamp8({1'b0, pwdata[`NM_LEVEL_LSB +: 7]},
                                 {1'b0, `NM_LEVEL_MIN}, {1'b0, `NM_LEVEL_MAX});
  wire [7:0]   wr_time  = clamp8(pwdata[`NM_TIME_LSB +: 8],
                                 `NM_TIME_MIN, `NM_TIME_MAX);
  wire [9:0]   wr_delay = (pwdata[9:0] > `LV_DELAY_MAX) ? `LV_DELAY_MAX : pwdata[9:0];

  wire prot_pkg::reaction_t opt_react =
    prot_pkg::reaction_t'(config_reg[`CFG_OPT_LSB +: 2]);
  wire         nm_react = config_reg[`CFG_NMR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // protection conditions

  wire [4:0]   block_sel = inputs_with(input_func, `FUNC_BLOCK);
  wire [4:0]   reset_sel = inputs_with(input_func, `FUNC_RESET);
  wire         block_in  = |(multi_function_input & block_sel);
  wire         reset_in  = |(multi_function_input & reset_sel);
  wire         running   = (state == prot_pkg::st_run);
  wire         new_cmd   = run_cmd && !run_cmd_q;
  wire         lv_low    = (dc_link_voltage < lv_level);
  // a reset input is edge taken so a held terminal cannot mask new trips
  wire         trip_reset = (reset_in && !reset_in_q) || key_reset;          // [RQ8] [RQ9]
  wire         opt_removed = option_present_q && !option_present && running;
  wire         opt_fault = option_comm_fail || opt_removed;                   // [RQ11]
  wire         opt_trip  = opt_fault && (opt_react != prot_pkg::react_none);  // [RQ12]
  wire         nm_low    = running && (output_current_pct < {1'b0, nm_level});

  timer_if lv_t ();
  timer_if nm_t ();

  assign lv_t.active = lv_low;
  assign lv_t.limit  = lv_delay;                                              // [RQ2]
  assign nm_t.active = nm_low;
  assign nm_t.limit  = {2'b00, nm_time};                                      // [RQ16]

  hold_timer #(.tenth_cycles(tenth_cycles)) lv_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (lv_t)
  );

  hold_timer #(.tenth_cycles(tenth_cycles)) nm_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (nm_t)
  );

  wire         lv_trip   = lv_t.expired;                                      // [RQ2]
  wire         nm_trip   = nm_t.expired && nm_react;                          // [RQ14] [RQ17]
  wire         any_trip  = lv_trip || opt_trip || nm_trip;
  // the decelerating option reaction and the unnamed code 3 leave the stage switching
  wire         trip_frees = lv_trip || nm_trip ||
                            (opt_trip && opt_react == prot_pkg::react_free_run);
  wire         in_trip   = (state == prot_pkg::st_trip);
  wire         block_entry = running && block_in && !any_trip;                // [RQ5]

  ////////////////////////////////////////////////////////////////////////////
  // drive state

  always_comb
  begin
    next_state = state;
    unique case (state)
      prot_pkg::st_stop:
        if (any_trip)
          next_state = prot_pkg::st_trip;
        else if (new_cmd && !block_in)
          next_state = prot_pkg::st_run;
      prot_pkg::st_run:
        if (any_trip)
          next_state = prot_pkg::st_trip;
        else if (block_in)
          next_state = prot_pkg::st_block;                                    // [RQ5]
        else if (!run_cmd)
          next_state = prot_pkg::st_stop;
      prot_pkg::st_block:
        if (any_trip)
          next_state = prot_pkg::st_trip;
        else if (!block_in && new_cmd)
          next_state = prot_pkg::st_run;                                      // [RQ7]
      prot_pkg::st_trip:
        if (trip_reset && !any_trip)
          next_state = prot_pkg::st_stop;                                     // [RQ19]
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state            <= prot_pkg::st_stop;
      run_cmd_q        <= 1'b0;
      reset_in_q       <= 1'b0;
      option_present_q <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      run_cmd_q        <= run_cmd;
      reset_in_q       <= reset_in;
      option_present_q <= option_present;
    end

  // cause bits accumulate while latched and clear only on a reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trip_cause  <= 3'h0;
      trip_blocks <= 1'b0;
    end
    else if (in_trip && trip_reset && !any_trip)
    begin
      trip_cause  <= 3'h0;                                                    // [RQ8] [RQ9]
      trip_blocks <= 1'b0;
    end
    else if (any_trip)
    begin
      trip_cause  <= trip_cause | {nm_trip, opt_trip, lv_trip};               // [RQ19]
      trip_blocks <= trip_blocks | trip_frees;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      held_freq    <= 16'h0000;
      held_current <= 16'h0000;
    end
    else if (block_entry && state == prot_pkg::st_run)
    begin
      held_freq    <= output_freq;                                            // [RQ6]
      held_current <= output_current;
    end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      output_block           <= 1'b0;
      decel_req              <= 1'b0;
      relay_one              <= 1'b0;
      relay_two              <= 1'b0;
      trip_active            <= 1'b0;
      block_display          <= 1'b0;
      fan_replacement_status <= `FAN_CLEAR;
    end
    else
    begin
      output_block  <= lv_low || next_state == prot_pkg::st_block ||          // [RQ1] [RQ5]
                       (next_state == prot_pkg::st_trip && (trip_blocks || trip_frees));
      decel_req     <= next_state == prot_pkg::st_trip &&                     // [RQ13]
                       (trip_cause[`EV_OPT] || opt_trip) &&
                       opt_react == prot_pkg::react_decel;
      // the warning follows the raw voltage, never the trip delay
      relay_one     <= lv_low && config_reg[`CFG_RELAY1_LSB +: 6] == `FUNC_LV_WARN; // [RQ3] [RQ4]
      relay_two     <= lv_low && config_reg[`CFG_RELAY2_LSB +: 6] == `FUNC_LV_WARN; // [RQ3] [RQ4]
      trip_active   <= next_state == prot_pkg::st_trip;                       // [RQ19]
      block_display <= next_state == prot_pkg::st_block;                      // [RQ5]
      fan_replacement_status <= fan_exchange_due ? `FAN_PENDING : `FAN_CLEAR; // [RQ10]
    end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and interrupt status

  wire [3:0]   events = {block_entry, nm_trip, opt_trip, lv_trip};
  wire [3:0]   w1c    = (wr && sel_ist) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      config_reg      <= 32'h0000_0000;
      lv_delay        <= `LV_DELAY_RST;
      lv_level        <= `LV_LEVEL_RST;
      nm_level        <= `NM_LEVEL_RST;
      nm_time         <= `NM_TIME_RST;
      input_func      <= 30'h0000_0000;
      trip_decel_time <= `DECEL_RST;
      irq_mask        <= 4'h0;
    end
    else if (wr)
    begin
      if (sel_cfg)
        config_reg <= pwdata;
      if (sel_lvd)
        lv_delay <= wr_delay;                                                 // [RQ2]
      if (sel_lvl)
        lv_level <= pwdata[15:0];
      if (sel_nm)
      begin
        nm_level <= wr_level[6:0];                                            // [RQ15]
        nm_time  <= wr_time;                                                  // [RQ16]
      end
      if (sel_func)
        input_func <= pwdata[29:0];
      if (sel_dec)
        trip_decel_time <= pwdata[15:0];                                      // [RQ13]
      if (sel_imsk)
        irq_mask <= pwdata[3:0];
    end

  // a fresh event outranks a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_status <= 4'h0;
    else
      irq_status <= (irq_status & ~w1c) | events;

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // read path

  wire [31:0] status_word = {16'h0000, 6'h00, fan_replacement_status,
                             trip_blocks, trip_cause, state};
  wire [31:0] rd_mux =
    sel_cfg  ? config_reg :
    sel_lvd  ? {22'h00_0000, lv_delay} :
    sel_lvl  ? {16'h0000, lv_level} :
    sel_nm   ? {16'h0000, nm_time, 1'b0, nm_level} :
    sel_func ? {2'b00, input_func} :
    sel_dec  ? {16'h0000, trip_decel_time} :
    sel_sts  ? status_word :
    sel_hold ? {held_current, held_freq} :
    sel_ist  ? {28'h000_0000, irq_status} :
    sel_imsk ? {28'h000_0000, irq_mask} : 32'h0000_0000;

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;

endmodule

// ### tb/trip_supervisor_assertions.sv
// concurrent checks on the trip supervisor ports
`timescale 1ns/1ps
module trip_supervisor_assertions #(
  parameter int unsigned tenth_cycles = 1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [4:0]  multi_function_input,
  input wire logic        key_reset,
  input wire logic        fan_exchange_due,
  input wire logic        output_block,
  input wire logic        decel_req,
  input wire logic        trip_active,
  input wire logic        block_display,
  input wire logic [1:0]  fan_replacement_status
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence apb_access;
    psel && penable;
  endsequence
  sequence quiet_reset;
    multi_function_input == 5'h00 && !key_reset;
  endsequence
  sequence quiet_trip;
    trip_active ##0 quiet_reset;
  endsequence
  sequence trip_hold;
    trip_active && !decel_req ##1 trip_active && !decel_req;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  err_phase_a: assert property (pslverr |-> apb_access)
    else $error("slave error outside an access phase");
  unmapped_err_a: assert property (apb_access ##0 paddr > 8'h24 |-> pslverr)
    else $error("unmapped access without slave error");
  mapped_ok_a: assert property (apb_access ##0 paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("slave error on a mapped register");
  // read data is loaded in the setup cycle only, so it may not move elsewhere
  read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");
  trip_block_a: assert property (trip_hold |-> output_block)
    else $error("latched trip without output block");
  decel_trip_a: assert property ($rose(decel_req) |-> trip_active && !output_block)
    else $error("deceleration request without a bare trip");
  trip_latch_a: assert property (quiet_trip ##1 quiet_trip |=> trip_active)
    else $error("trip cleared without a reset request");
  block_out_a: assert property (block_display |-> output_block)
    else $error("block indication with output running");
  fan_status_a: assert property ($past(presetn) |->
    fan_replacement_status == {1'b0, $past(fan_exchange_due)})
    else $error("fan status does not follow the exchange flag");
endmodule

bind trip_supervisor trip_supervisor_assertions #(.tenth_cycles(tenth_cycles))
  trip_supervisor_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .multi_function_input(multi_function_input),
  .key_reset(key_reset), .fan_exchange_due(fan_exchange_due), .output_block(output_block),
  .decel_req(decel_req), .trip_active(trip_active), .block_display(block_display),
  .fan_replacement_status(fan_replacement_status)
);

// ### tb/power_stage_model.sv
// power stage and motor model: dc link level and output current percentage
`timescale 1ns/1ps
module power_stage_model (
  input  wire logic        pclk,
  input  wire logic        supply_lost,
  input  wire logic        motor_connected,
  input  wire logic        output_block,
  output logic      [15:0] dc_link_voltage = 16'h0200,
  output logic      [7:0]  output_current_pct = 8'h02
);
  always @(posedge pclk)
  begin
    // a lost supply sags the link far below any threshold the bench programs
    dc_link_voltage <= supply_lost ? 16'h0040 : 16'h0200;
    // an open lead or a blocked stage leaves only a small residual current
    output_current_pct <= (motor_connected && !output_block) ? 8'h28 : 8'h02;
  end
endmodule

// ### tb/trip_supervisor_bench.sv
// self-checking bench for the trip supervisor
`timescale 1ns/1ps
`include "prot_cfg.svh"
module trip_supervisor_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, output_block, decel_req, relay_one, relay_two;
  logic        trip_active, block_display, irq;
  logic [15:0] dc_link_voltage, trip_decel_time, hf, hc, dv;
  logic [15:0] output_freq = 16'h0;
  logic [15:0] output_current = 16'h0;
  logic [7:0]  output_current_pct;
  logic [4:0]  multi_function_input = 5'h00;
  logic        run_cmd = 1'b0;
  logic        key_reset = 1'b0;
  logic        option_comm_fail = 1'b0;
  logic        option_present = 1'b1;
  logic        fan_exchange_due = 1'b0;
  logic        supply_lost = 1'b0;
  logic        motor_connected = 1'b1;
  logic [1:0]  fan_replacement_status, r;
  logic [15:0] seed = 16'hcfdb;
  logic [32:0] expect_q[$];
  int          failures = 0;
  int          checks = 0;

  always #5 pclk = ~pclk;

  trip_supervisor #(.tenth_cycles(4)) trip_supervisor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dc_link_voltage(dc_link_voltage), .output_freq(output_freq),
    .output_current(output_current), .output_current_pct(output_current_pct),
    .multi_function_input(multi_function_input), .run_cmd(run_cmd), .key_reset(key_reset),
    .option_comm_fail(option_comm_fail), .option_present(option_present),
    .fan_exchange_due(fan_exchange_due), .output_block(output_block), .decel_req(decel_req),
    .trip_decel_time(trip_decel_time), .relay_one(relay_one), .relay_two(relay_two),
    .trip_active(trip_active), .block_display(block_display),
    .fan_replacement_status(fan_replacement_status), .irq(irq));
  power_stage_model power_stage_model_inst (
    .pclk(pclk), .supply_lost(supply_lost), .motor_connected(motor_connected),
    .output_block(output_block), .dc_link_voltage(dc_link_voltage),
    .output_current_pct(output_current_pct));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks++;
    if (seen !== want)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // settled outputs are looked at on the falling edge, away from any update
  task automatic look();
    @(negedge pclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expect_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // read results are compared at the edge that completes the transfer
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, expect_q.pop_front());
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    presetn <= 1'b1;
    look();
    check(pready, 1'b1);
    rd(`OFF_LV_DELAY, 33'h0);
    rd(`OFF_NO_MOTOR, 33'h1e05);
    rd(8'h28, 33'h100000000);
    wr(`OFF_LV_DELAY, 32'h3ff);
    rd(`OFF_LV_DELAY, 33'h258);
    wr(`OFF_NO_MOTOR, 32'h0);
    rd(`OFF_NO_MOTOR, 33'h0101);
    wr(`OFF_NO_MOTOR, 32'hffff);
    rd(`OFF_NO_MOTOR, 33'h6464);
    wr(`OFF_NO_MOTOR, 32'h0103);
    wr(`OFF_LV_DELAY, 32'h2);
    wr(`OFF_LV_LEVEL, 32'h0100);
    wr(`OFF_CONFIG, 32'h0b);
    wr(`OFF_INPUT_FUNC, 32'h143);
    wr(`OFF_IRQ_MASK, 32'hf);
    supply_lost <= 1'b1;
    cyc(2);
    look();
    check(output_block, 1'b1);
    check({relay_one, relay_two}, 2'h2);
    check(trip_active, 1'b0);
    cyc(4);
    look();
    check(trip_active, 1'b0);
    cyc(8);
    supply_lost <= 1'b0;
    look();
    check(trip_active, 1'b1);
    cyc(4);
    look();
    check({trip_active, output_block, irq}, 3'h7);
    rd(`OFF_STATUS, 33'h98);
    rd(`OFF_IRQ_STATUS, 33'h1);
    wr(`OFF_IRQ_STATUS, 32'h1);
    look();
    check(irq, 1'b0);
    cyc(1);
    key_reset <= 1'b1;
    cyc(1);
    key_reset <= 1'b0;
    rd(`OFF_STATUS, 33'h1);
    seed = lfsr(seed);
    hf = seed;
    seed = lfsr(seed);
    hc = seed;
    output_freq <= hf;
    output_current <= hc;
    run_cmd <= 1'b1;
    cyc(2);
    multi_function_input <= 5'h02;
    cyc(3);
    output_freq <= ~hf;
    output_current <= ~hc;
    run_cmd <= 1'b0;
    look();
    check({block_display, output_block}, 2'h3);
    rd(`OFF_HOLD, {1'b0, hc, hf});
    run_cmd <= 1'b1;
    cyc(2);
    multi_function_input <= 5'h00;
    cyc(3);
    look();
    check(block_display, 1'b1);
    cyc(1);
    run_cmd <= 1'b0;
    cyc(1);
    run_cmd <= 1'b1;
    fan_exchange_due <= 1'b1;
    cyc(3);
    look();
    check({block_display, output_block, fan_replacement_status}, 4'h1);
    rd(`OFF_STATUS, 33'h102);
    rd(`OFF_IRQ_STATUS, 33'h8);
    wr(`OFF_IRQ_STATUS, 32'hf);
    fan_exchange_due <= 1'b0;
    run_cmd <= 1'b0;
    seed = lfsr(seed);
    dv = seed;
    wr(`OFF_DECEL, {16'h0, dv});
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 3) ? 2'h1 : i[1:0];
      wr(`OFF_CONFIG, {14'h0, r, 16'h000b});
      run_cmd <= 1'b1;
      cyc(2);
      if (i == 3)
        option_present <= 1'b0;
      else
        option_comm_fail <= 1'b1;
      cyc(3);
      key_reset <= 1'b1;
      look();
      check({trip_active, output_block}, {r != 2'h0, r == 2'h1});
      check({decel_req, trip_decel_time}, {r == 2'h2, dv});
      cyc(1);
      key_reset <= 1'b0;
      cyc(2);
      look();
      if (i < 3)
        check(trip_active, r != 2'h0);
      cyc(1);
      option_comm_fail <= 1'b0;
      option_present <= 1'b1;
      run_cmd <= 1'b0;
      cyc(2);
      multi_function_input <= {4'h0, i[0]};
      key_reset <= !i[0];
      cyc(1);
      multi_function_input <= 5'h00;
      key_reset <= 1'b0;
      cyc(2);
      look();
      check({trip_active, decel_req}, 2'h0);
      wr(`OFF_IRQ_STATUS, 32'hf);
    end
    motor_connected <= 1'b0;
    run_cmd <= 1'b1;
    cyc(12);
    run_cmd <= 1'b0;
    look();
    check(trip_active, 1'b0);
    wr(`OFF_CONFIG, 32'h10000b);
    run_cmd <= 1'b1;
    cyc(12);
    look();
    check({trip_active, output_block}, 2'h3);
    rd(`OFF_STATUS, 33'hc8);
    motor_connected <= 1'b1;
    run_cmd <= 1'b0;
    key_reset <= 1'b1;
    cyc(1);
    key_reset <= 1'b0;
    cyc(2);
    look();
    check(trip_active, 1'b0);
    stop_test();
  end
  // the sequence needs well under a thousand cycles; a hang ends here
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test();
  end
endmodule
